// ---- dv/nvm_far_model.sv ----
// Far-side model: flash array erase engine and factory signature row read port.
// Assumes the guard's clock and synchronous reset.
`timescale 1ns/1ns
module nvm_far_model #(
    parameter int DLY = 4
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Erase handshake
    input  wire logic       flash_erase_q,
    output logic            flash_erase_done,
    // Signature row read
    input  wire logic [6:0] cal_addr_q,
    output logic [7:0]      cal_rdata
);
    int cnt_q;
    // A fixed pattern per address lets the bench predict every loaded byte.
    assign cal_rdata = 8'h5A + {1'b0, cal_addr_q};
    // The array erase takes several cycles, so the guard must wait for it.
    always @(posedge clk) begin
        cnt_q <= !rst_n ? 0 : flash_erase_q ? DLY : (cnt_q > 0 ? cnt_q - 1 : 0);
        flash_erase_done <= rst_n && cnt_q == 1;
    end
endmodule

// ---- dv/nvm_map_guard_sva.sv ----
// Checker for the memory map decoder and flash guard.
// Sees only the guard's ports; attached by the bind at the foot.
`timescale 1ns/1ns
module nvm_map_guard_sva #(
    parameter [15:0] BOOT_START = 16'hF000,
    parameter [23:0] SRAM_LAST  = 24'h00_3FFF,
    parameter [23:0] EE_LAST    = 24'h00_17FF
) (
    input wire logic        clk, rst_n, dat_short_io, dat_bit_op, ee_map_en,
    input wire logic [23:0] dat_addr,
    input wire logic        sel_ee_q, sel_sram_q, fl_req, fl_write, fl_from_port,
    input wire logic [15:0] fl_addr, exec_pc, fl_addr_q,
    input wire logic        fl_wr_en_q, lock_wr, erase_busy_q, flash_erase_done,
    input wire logic [7:0]  lock_byte_q,
    input wire logic        sig_req, sig_write, sig_user, sig_denied_q,
    input wire logic        chip_erase, usig_erase, usig_erase_q, user_sig_wr_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_sram;
        (dat_addr >= 24'h00_2000 && dat_addr <= SRAM_LAST && !dat_short_io && !dat_bit_op)
            |=> sel_sram_q;
    endproperty
    a_sram: assert property (p_sram)
        else $error("sram not selected");
    property p_ee;
        (ee_map_en && dat_addr >= 24'h00_1000 && dat_addr <= EE_LAST && !dat_short_io
            && !dat_bit_op) |=> sel_ee_q;
    endproperty
    a_ee: assert property (p_ee)
        else $error("mapped eeprom not selected");
    property p_spm_app;
        (fl_req && fl_write && !fl_from_port && exec_pc < BOOT_START) |=> !fl_wr_en_q;
    endproperty
    a_spm_app: assert property (p_spm_app)
        else $error("store from application section went through");
    // Lock levels lag by a cycle, so recent lock writes and erases are excluded.
    property p_spm_boot;
        (fl_req && fl_write && !fl_from_port && exec_pc >= BOOT_START && fl_addr >= BOOT_START
            && lock_byte_q[5:4] == 2'b11 && !lock_wr && !$past(lock_wr) && !$past(lock_wr, 2)
            && !erase_busy_q && !chip_erase) |=> fl_wr_en_q && fl_addr_q == $past(fl_addr);
    endproperty
    a_spm_boot: assert property (p_spm_boot)
        else $error("store from boot section refused");
    property p_no_loosen;
        (|(lock_byte_q & ~$past(lock_byte_q))) |-> ($past(erase_busy_q) || $past(erase_busy_q, 2));
    endproperty
    a_no_loosen: assert property (p_no_loosen)
        else $error("lock loosened without erase");
    property p_erase_order;
        $fell(erase_busy_q) |-> ($past(flash_erase_done) || $past(flash_erase_done, 2));
    endproperty
    a_erase_order: assert property (p_erase_order)
        else $error("erase ended before flash was cleared");
    property p_prod_sig;
        (sig_req && sig_write && !sig_user) |=> sig_denied_q && !user_sig_wr_q;
    endproperty
    a_prod_sig: assert property (p_prod_sig)
        else $error("production row write not refused");
    property p_keep_usig;
        erase_busy_q |=> !usig_erase_q;
    endproperty
    a_keep_usig: assert property (p_keep_usig)
        else $error("chip erase touched user row");
endmodule
bind nvm_map_guard nvm_map_guard_sva #(
    .BOOT_START(BOOT_START),
    .SRAM_LAST (SRAM_LAST),
    .EE_LAST   (EE_LAST)
) nvm_map_guard_sva_inst (.*);

// ---- dv/test_memory_map_and_nvm_protection.sv ----
// Self-checking bench for the memory map decoder and flash guard.
// Drives every request port and runs the far-side model beside the guard.
`timescale 1ns/1ns
module test_memory_map_and_nvm_protection;
    logic clk = 0, rst_n = 0, dat_short_io = 0, dat_bit_op = 0, ee_map_en = 0;
    logic ee_page_mode = 0, fl_req = 0, fl_write = 0, fl_from_port = 0, instr_two_words = 0;
    logic lock_wr = 0, fuse_wr = 0, fuse_from_port = 0, chip_erase = 0, usig_erase = 0;
    logic sig_req = 0, sig_write = 0, sig_user = 0, flash_erase_done;
    logic [23:0] dat_addr = 0;
    logic [15:0] fl_addr = 0, fl_wdata = 0, exec_pc = 0, fl_addr_q, fl_wdata_q;
    logic [1:0] lock_sec = 0, lock_val = 0, cal_target_q;
    logic [2:0] fuse_idx = 0;
    logic [7:0] fuse_val = 0, cal_rdata, lock_byte_q, fuse_rd_q, cal_data_q;
    logic [6:0] cal_addr_q;
    logic sel_io_q, sel_ee_q, sel_sram_q, sel_ext_q, sel_fault_q, ee_page_q, fl_rd_en_q;
    logic fl_wr_en_q, fl_denied_q, pc_step2_q, flash_erase_q, usig_erase_q, erase_busy_q;
    logic prod_sig_rd_q, user_sig_rd_q, user_sig_wr_q, sig_denied_q, cal_load_q, cal_done_q;
    int err_count = 0, cmp_count = 0, cyc = 0;
    nvm_map_guard nvm_map_guard_inst (.*);
    nvm_far_model nvm_far_model_inst (.*);
    always #4 clk = ~clk;
    task chk(input logic [23:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task fl(input logic wr, port, input logic [15:0] pc, a);
        @(posedge clk);
        {fl_req, fl_write, fl_from_port, exec_pc, fl_addr, fl_wdata} <= {1'b1, wr, port, pc, a,
            16'hC3A5};
        @(posedge clk);
        fl_req <= 1'b0;
        #1;
    endtask
    task lk(input logic [1:0] s, v);
        @(posedge clk);
        {lock_wr, lock_sec, lock_val} <= {1'b1, s, v};
        @(posedge clk);
        lock_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task fz(input logic p, input logic [7:0] v);
        @(posedge clk);
        {fuse_wr, fuse_from_port, fuse_idx, fuse_val} <= {1'b1, p, 3'd2, v};
        @(posedge clk);
        fuse_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task sg(input logic w, u);
        @(posedge clk);
        {sig_req, sig_write, sig_user} <= {1'b1, w, u};
        @(posedge clk);
        sig_req <= 1'b0;
        #1;
    endtask
    task t_cal;
        int k;
        k = 0;
        for (int n = 0; n < 20 && cal_done_q !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (cal_load_q === 1'b1) begin
                chk(cal_target_q, k[1:0], "cal target");
                chk(cal_data_q, 8'h5A + k[7:0], "cal data");
                k++;
            end
        end
        chk(k[7:0], 3, "cal count");
        $display("test cal done");
    endtask
    task t_map;
        // Entry: address, {short, bit, page, map}, expected {io, ee, sram, ext, fault, page}.
        logic [33:0] tb[14];
        logic [5:0] sel;
        tb = '{{24'h00_0010, 4'b0000, 6'b100000}, {24'h00_1000, 4'b0001, 6'b010000},
            {24'h00_17FF, 4'b0011, 6'b010001}, {24'h00_1800, 4'b0001, 6'b000010},
            {24'h00_1000, 4'b0010, 6'b000010}, {24'h00_2000, 4'b0000, 6'b001000},
            {24'h00_3FFF, 4'b0000, 6'b001000}, {24'h00_4000, 4'b0000, 6'b000100},
            {24'hFF_FFFF, 4'b0000, 6'b000100}, {24'h00_003F, 4'b1000, 6'b100000},
            {24'h00_0040, 4'b1000, 6'b000010}, {24'h00_001F, 4'b0100, 6'b100000},
            {24'h00_0020, 4'b0100, 6'b000010}, {24'h00_0FFF, 4'b0000, 6'b100000}};
        foreach (tb[i]) begin
            @(posedge clk);
            {dat_addr, dat_short_io, dat_bit_op, ee_page_mode, ee_map_en} <= tb[i][33:6];
            @(posedge clk);
            #1 sel = {sel_io_q, sel_ee_q, sel_sram_q, sel_ext_q, sel_fault_q, ee_page_q};
            chk(sel, tb[i][5:0], "map");
        end
        $display("test map done");
    endtask
    task t_flash;
        fl(1, 0, 16'h0100, 16'h0200);
        chk(fl_wr_en_q, 0, "store from app");
        fl(1, 0, 16'hF010, 16'hF800);
        chk({fl_wr_en_q, fl_addr_q}, {1'b1, 16'hF800}, "store from boot");
        chk(fl_wdata_q, 16'hC3A5, "word data");
        @(posedge clk);
        instr_two_words <= 1'b1;
        @(posedge clk);
        instr_two_words <= 1'b0;
        #1 chk(pc_step2_q, 1, "two words");
        fl(0, 1, 16'h0000, 16'h0040);
        chk(fl_rd_en_q, 1, "port read");
        lk(2'd1, 2'b10);
        chk(lock_byte_q, 8'hFB, "table lock");
        fl(1, 1, 16'h0000, 16'hE100);
        chk({fl_wr_en_q, fl_denied_q}, 2'b01, "table write");
        fl(1, 1, 16'h0000, 16'h0100);
        chk(fl_wr_en_q, 1, "app write");
        lk(2'd0, 2'b10);
        lk(2'd0, 2'b11);
        chk(lock_byte_q, 8'hFA, "no loosen");
        lk(2'd2, 2'b00);
        chk(lock_byte_q, 8'hCA, "boot lock");
        fl(0, 1, 16'h0000, 16'hF100);
        chk(fl_rd_en_q, 0, "boot read");
        fl(0, 0, 16'hF010, 16'h0100);
        chk(fl_rd_en_q, 1, "app read");
        $display("test flash done");
    endtask
    task t_misc;
        fz(1'b1, 8'h5A);
        chk(fuse_rd_q, 8'h5A, "port fuse");
        fz(1'b0, 8'h00);
        chk(fuse_rd_q, 8'h5A, "soft fuse");
        sg(1, 0);
        chk(sig_denied_q, 1, "prod write");
        sg(0, 0);
        chk(prod_sig_rd_q, 1, "prod read");
        sg(1, 1);
        chk(user_sig_wr_q, 1, "user write");
        sg(0, 1);
        chk(user_sig_rd_q, 1, "user read");
        $display("test fuse and rows done");
    endtask
    task t_erase;
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
        #1 chk(flash_erase_q, 1, "erase start");
        fl(1, 1, 16'h0000, 16'h0100);
        chk(fl_denied_q, 1, "write in erase");
        for (int n = 0; n < 40 && lock_byte_q !== 8'hFF; n++) begin
            @(posedge clk);
            // A user row erase issued mid chip erase must not pass.
            usig_erase <= (n == 0);
            #1 chk(usig_erase_q, 0, "user row kept");
            if (erase_busy_q === 1'b1)
                chk(lock_byte_q, 8'hCA, "locks held");
        end
        chk({lock_byte_q, erase_busy_q}, {8'hFF, 1'b0}, "locks cleared");
        @(posedge clk);
        usig_erase <= 1'b1;
        @(posedge clk);
        usig_erase <= 1'b0;
        #1 chk(usig_erase_q, 1, "user row erase");
        $display("test erase done");
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_cal();
        t_map();
        t_flash();
        t_misc();
        t_erase();
        print_verdict();
    end
endmodule

// ---- src/lock_level_merge.v ----
// Merges a requested lock level into a stored one, never loosening it.
// Inverted encoding: a programmed bit is zero, so tightening only clears bits.
`timescale 1ns/1ns
module lock_level_merge (
    // Levels
    input  wire [1:0] cur_level,
    input  wire [1:0] req_level,
    // Result
    output wire [1:0] new_level
);
    // Bits may go from one to zero only, so the merge is a plain AND.
    assign new_level = cur_level & req_level;
endmodule

// ---- src/nvm_map_defs.vh ----
// Constants for the data memory decoder and the nonvolatile memory guard.
// Included by the design files; holds definitions only.
`ifndef NVM_MAP_DEFS_VH
`define NVM_MAP_DEFS_VH
`define ADDR_W          24
`define IO_DIRECT_LAST  24'h00_003F
`define IO_BIT_LAST     24'h00_001F
`define IO_SPACE_LAST   24'h00_0FFF
`define EE_BASE         24'h00_1000
`define SRAM_BASE       24'h00_2000
`define EXT_LAST        24'hFF_FFFF
`define FLASH_AW        16
`define WORD_W          16
`define SIG_AW          7
// Lock level: 2'b11 none, 2'b10 write blocked, 2'b0x read and write blocked.
`define LOCK_NONE       2'b11
`define LOCK_NO_WRITE   2'b10
`define LOCK_ERASED     8'hFF
// Sections.
`define SEC_APP         2'h0
`define SEC_TABLE       2'h1
`define SEC_BOOT        2'h2
`endif

// ---- src/nvm_map_guard.v ----
// Data memory decoder and nonvolatile memory access guard.
// Assumes a single clock shared with the core and the debug port logic;
// all request inputs are synchronous to clk and the flash array is external.
`timescale 1ns/1ns
`include "nvm_map_defs.vh"
// Operation
// - Store-program-word only programs when fetched from the boot loader section.
// - From boot section, the store can reach every flash word including boot.
// - Flash words are 16 bits; instructions take one or two words.
// - Table region equals boot size and has its own lock level.
// - Application and boot sections carry independent lock levels.
// - Lock writes from either source may only tighten protection.
// - Only chip erase clears locks, and only after all flash is erased; here reset also sets every lock level to none.
// - Fuse and lock bits read one unprogrammed, zero programmed.
// - Fuses are written only by the debug port; software reads only.
// - Production signature row refuses every write and erase; readable by all.
// - Reset copies selected calibration values from the signature row.
// - User signature row is readable and writable by software and debug port.
// - Chip erase leaves user signature row; its own erase clears it.
// - Internal SRAM starts at data address 0x2000.
// - Mapped EEPROM appears at 0x1000 when mapping is enabled.
// - External memory spans from after last SRAM byte to 0xFFFFFF.
// - Short I/O instructions reach 0x00 to 0x3F; loads reach all I/O.
// - Bit set, clear and test are allowed for I/O 0x00 to 0x1F.
// - EEPROM supports byte and page access.
// - Flash is reachable from the debug port and from software.
module nvm_map_guard #(
    parameter [`FLASH_AW-1:0] BOOT_START  = 16'hF000,
    parameter [`FLASH_AW-1:0] TABLE_START = 16'hE000,
    parameter [`ADDR_W-1:0]   SRAM_LAST   = 24'h00_3FFF,
    parameter [`ADDR_W-1:0]   EE_LAST     = 24'h00_17FF
) (
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst_n,
    // Data space decode
    input  wire [`ADDR_W-1:0]   dat_addr,
    input  wire                 dat_short_io,
    input  wire                 dat_bit_op,
    input  wire                 ee_map_en,
    input  wire                 ee_page_mode,
    output reg                  sel_io_q,
    output reg                  sel_ee_q,
    output reg                  sel_sram_q,
    output reg                  sel_ext_q,
    output reg                  sel_fault_q,
    output reg                  ee_page_q,
    // Flash access request, from core or debug port
    input  wire                 fl_req,
    input  wire                 fl_write,
    input  wire                 fl_from_port,
    input  wire [`FLASH_AW-1:0] fl_addr,
    input  wire [`WORD_W-1:0]   fl_wdata,
    input  wire [`FLASH_AW-1:0] exec_pc,
    input  wire                 instr_two_words,
    output reg                  fl_rd_en_q,
    output reg                  fl_wr_en_q,
    output reg  [`FLASH_AW-1:0] fl_addr_q,
    output reg  [`WORD_W-1:0]   fl_wdata_q,
    output reg                  fl_denied_q,
    output reg                  pc_step2_q,
    // Lock and fuse programming
    input  wire                 lock_wr,
    input  wire [1:0]           lock_sec,
    input  wire [1:0]           lock_val,
    input  wire                 fuse_wr,
    input  wire                 fuse_from_port,
    input  wire [2:0]           fuse_idx,
    input  wire [7:0]           fuse_val,
    output reg  [7:0]           lock_byte_q,
    output reg  [7:0]           fuse_rd_q,
    // Erase
    input  wire                 chip_erase,
    input  wire                 flash_erase_done,
    input  wire                 usig_erase,
    output reg                  flash_erase_q,
    output reg                  usig_erase_q,
    output reg                  erase_busy_q,
    // Signature rows
    input  wire                 sig_req,
    input  wire                 sig_write,
    input  wire                 sig_user,
    output reg                  prod_sig_rd_q,
    output reg                  user_sig_rd_q,
    output reg                  user_sig_wr_q,
    output reg                  sig_denied_q,
    // Calibration load at reset
    input  wire [7:0]           cal_rdata,
    output reg  [`SIG_AW-1:0]   cal_addr_q,
    output reg                  cal_load_q,
    output reg  [1:0]           cal_target_q,
    output reg  [7:0]           cal_data_q,
    output reg                  cal_done_q
);
    localparam CAL_N = 3;
    localparam [1:0] ER_IDLE  = 2'd0;
    localparam [1:0] ER_FLASH = 2'd1;
    localparam [1:0] ER_LOCK  = 2'd2;

    reg  [1:0]         lvl_q [0:2];
    reg  [7:0]         fuse_q [0:7];
    reg  [1:0]         er_state_q;
    reg  [1:0]         cal_idx_q;
    reg                cal_wait_q;
    wire [1:0]         merged;
    reg  [1:0]         sec;
    reg  [1:0]         lvl;
    reg                ok;
    wire               in_boot_pc;
    integer            i;

    lock_level_merge u_merge (
        .cur_level (lvl_q[lock_sec]),
        .req_level (lock_val),
        .new_level (merged)
    );

    assign in_boot_pc = (exec_pc >= BOOT_START);

    // Data address decode, registered.
    always @(posedge clk) begin
        if (!rst_n) begin
            sel_io_q    <= 1'b0;
            sel_ee_q    <= 1'b0;
            sel_sram_q  <= 1'b0;
            sel_ext_q   <= 1'b0;
            sel_fault_q <= 1'b0;
            ee_page_q   <= 1'b0;
        end else begin
            sel_io_q    <= 1'b0;
            sel_ee_q    <= 1'b0;
            sel_sram_q  <= 1'b0;
            sel_ext_q   <= 1'b0;
            sel_fault_q <= 1'b0;
            ee_page_q   <= 1'b0;
            if (dat_bit_op) begin
                sel_io_q    <= (dat_addr <= `IO_BIT_LAST);
                sel_fault_q <= (dat_addr >  `IO_BIT_LAST);
            end else if (dat_short_io) begin
                sel_io_q    <= (dat_addr <= `IO_DIRECT_LAST);
                sel_fault_q <= (dat_addr >  `IO_DIRECT_LAST);
            end else if (dat_addr <= `IO_SPACE_LAST) begin
                sel_io_q <= 1'b1;
            end else if (dat_addr >= `EE_BASE && dat_addr <= EE_LAST) begin
                // Unmapped EEPROM is reached only through its own data space.
                sel_ee_q    <= ee_map_en;
                sel_fault_q <= !ee_map_en;
                ee_page_q   <= ee_map_en & ee_page_mode;
            end else if (dat_addr >= `SRAM_BASE && dat_addr <= SRAM_LAST) begin
                sel_sram_q <= 1'b1;
            end else if (dat_addr > SRAM_LAST && dat_addr <= `EXT_LAST) begin
                sel_ext_q <= 1'b1;
            end else begin
                sel_fault_q <= 1'b1;
            end
        end
    end

    // Section of the requested flash word.
    always @* begin
        if (fl_addr >= BOOT_START)
            sec = `SEC_BOOT;
        else if (fl_addr >= TABLE_START)
            sec = `SEC_TABLE;
        else
            sec = `SEC_APP;
        lvl = lvl_q[sec];
        if (fl_write)
            ok = (lvl == `LOCK_NONE) && (fl_from_port || in_boot_pc);
        else
            ok = lvl[1];
    end

    // Flash gating.
    always @(posedge clk) begin
        if (!rst_n) begin
            fl_rd_en_q  <= 1'b0;
            fl_wr_en_q  <= 1'b0;
            fl_addr_q   <= {`FLASH_AW{1'b0}};
            fl_wdata_q  <= {`WORD_W{1'b0}};
            fl_denied_q <= 1'b0;
            pc_step2_q  <= 1'b0;
        end else begin
            fl_rd_en_q  <= fl_req & !fl_write & ok & !erase_busy_q;
            fl_wr_en_q  <= fl_req & fl_write & ok & !erase_busy_q;
            fl_denied_q <= fl_req & (!ok | erase_busy_q);
            fl_addr_q   <= fl_addr;
            fl_wdata_q  <= fl_wdata;
            pc_step2_q  <= instr_two_words;
        end
    end

    // Locks, fuses and chip erase sequencing.
    always @(posedge clk) begin
        if (!rst_n) begin
            er_state_q    <= ER_IDLE;
            flash_erase_q <= 1'b0;
            erase_busy_q  <= 1'b0;
            usig_erase_q  <= 1'b0;
            lock_byte_q   <= `LOCK_ERASED;
            fuse_rd_q     <= `LOCK_ERASED;
        end else begin
            flash_erase_q <= 1'b0;
            usig_erase_q  <= usig_erase & !erase_busy_q;
            fuse_rd_q     <= fuse_q[fuse_idx];
            lock_byte_q   <= {2'b11, lvl_q[`SEC_BOOT], lvl_q[`SEC_TABLE],
                              lvl_q[`SEC_APP]};
            case (er_state_q)
                ER_IDLE: begin
                    if (chip_erase) begin
                        er_state_q    <= ER_FLASH;
                        flash_erase_q <= 1'b1;
                        erase_busy_q  <= 1'b1;
                    end
                end
                ER_FLASH: begin
                    // Locks stay set until the array reports erased.
                    if (flash_erase_done)
                        er_state_q <= ER_LOCK;
                end
                ER_LOCK: begin
                    er_state_q   <= ER_IDLE;
                    erase_busy_q <= 1'b0;
                end
                default: begin
                    er_state_q <= ER_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < 3; i = i + 1)
                lvl_q[i] <= `LOCK_NONE;
            for (i = 0; i < 8; i = i + 1)
                fuse_q[i] <= `LOCK_ERASED;
        end else begin
            if (er_state_q == ER_LOCK) begin
                for (i = 0; i < 3; i = i + 1)
                    lvl_q[i] <= `LOCK_NONE;
            end else if (lock_wr && lock_sec <= `SEC_BOOT) begin
                lvl_q[lock_sec] <= merged;
            end
            if (fuse_wr && fuse_from_port)
                fuse_q[fuse_idx] <= fuse_val;
        end
    end

    // Signature rows: production row never written.
    always @(posedge clk) begin
        if (!rst_n) begin
            prod_sig_rd_q <= 1'b0;
            user_sig_rd_q <= 1'b0;
            user_sig_wr_q <= 1'b0;
            sig_denied_q  <= 1'b0;
        end else begin
            prod_sig_rd_q <= sig_req & !sig_user & !sig_write;
            sig_denied_q  <= sig_req & !sig_user & sig_write;
            user_sig_rd_q <= sig_req & sig_user & !sig_write;
            user_sig_wr_q <= sig_req & sig_user & sig_write;
        end
    end

    // Calibration copy while reset releases: reads CAL_N signature bytes.
    always @(posedge clk) begin
        if (!rst_n) begin
            cal_idx_q    <= 2'd0;
            cal_wait_q   <= 1'b0;
            cal_addr_q   <= {`SIG_AW{1'b0}};
            cal_load_q   <= 1'b0;
            cal_target_q <= 2'd0;
            cal_data_q   <= 8'h00;
            cal_done_q   <= 1'b0;
        end else begin
            cal_load_q <= 1'b0;
            if (!cal_done_q) begin
                if (!cal_wait_q) begin
                    cal_addr_q <= {{(`SIG_AW-2){1'b0}}, cal_idx_q};
                    cal_wait_q <= 1'b1;
                end else begin
                    cal_wait_q   <= 1'b0;
                    cal_load_q   <= 1'b1;
                    cal_target_q <= cal_idx_q;
                    cal_data_q   <= cal_rdata;
                    cal_idx_q    <= cal_idx_q + 2'd1;
                    if (cal_idx_q == CAL_N - 1)
                        cal_done_q <= 1'b1;
                end
            end
        end
    end
endmodule
